/* core/dsd_decoder.sv */
// How it works
// R1: decode select register bit n routes digit n through font, else bypass.
// R2: one feature bit picks bcd or hex font for every decoded digit.
// R3: decoded digit looks only at low nibble, bits six to four ignored.
// R4: digit bit 7 drives decimal point directly, active high, always.
// R5: undecoded digit maps bits 7..0 to decimal point, a, b, c, d, e, f, g.
// R6: bcd font shows numerals zero to nine plus e, h, l, p, minus.
// R7: hex font shows zero to nine then a to f, ascending.
// R8: bcd nibble 10 minus, 11 e, 12 h, 13 l, 14 p, 15 blank.
// R9: self addressing takes g and f key nodes, which stop reporting keys.
// R10: sampled nodes form the two lowest bus address bits.
// R11: after power-up the bus address is all zeros.
// R12: one self-addressing write at default address updates every device.
// R13: host must repeat self-addressing write after each power-up.
// R14: shorted node reads zero, open node reads one.
// R15: address nodes sampled without debounce; straps must be fixed.
// R16: address source bit 0: zero factory address, one user address.
// R17: segments recomputed from current registers at each digit scan.
`timescale 1ns/100ps
`default_nettype none

module dsd_decoder #(
  parameter int NUM_DIGITS = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire dsd_pkg::dsd_wr_s i_reg_wr,
  input  wire logic             i_reg_rd_en,
  input  wire logic       [7:0] i_reg_rd_addr,
  output logic            [7:0] o_reg_rd_data,
  output logic                  o_reg_rd_valid,
  input  wire logic             i_scan_strobe,
  input  wire logic       [2:0] i_scan_digit,
  output dsd_pkg::dsd_seg_s     o_segments,
  input  wire logic             i_node_g_open,
  input  wire logic             i_node_f_open,
  output logic            [6:0] o_bus_address,
  output logic            [7:0] o_key_report_mask
);
  import dsd_pkg::*;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // one strobe per register keeps each storage process a single compare
  logic [NUM_DIGITS-1:0] wr_digit;
  logic                  wr_decode_select;
  logic                  wr_feature;
  logic                  wr_addr_source;

  assign wr_decode_select = i_reg_wr.en && (i_reg_wr.addr == DSD_OFS_DECODE_SELECT);
  assign wr_feature       = i_reg_wr.en && (i_reg_wr.addr == DSD_OFS_FEATURE);
  assign wr_addr_source   = i_reg_wr.en && (i_reg_wr.addr == DSD_OFS_ADDR_SOURCE); // R12

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] digit_reg [NUM_DIGITS];
  logic [7:0] digit_decode_select_reg;
  logic [7:0] feature_reg;
  logic [7:0] bus_address_source_reg;
  logic [1:0] node_sample_reg;

  // per-digit storage, one writer each
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_digit
      localparam logic [7:0] OFS = DSD_OFS_DIGIT0 + 8'(gi);
      assign wr_digit[gi] = i_reg_wr.en && (i_reg_wr.addr == OFS);
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          digit_reg[gi] <= DSD_RST_DIGIT;
        end else if (wr_digit[gi]) begin
          digit_reg[gi] <= i_reg_wr.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      digit_decode_select_reg <= DSD_RST_DECODE;
    end else if (wr_decode_select) begin
      digit_decode_select_reg <= i_reg_wr.data; // R1
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      feature_reg <= DSD_RST_FEATURE;
    end else if (wr_feature) begin
      feature_reg <= i_reg_wr.data;
    end
  end

  // every device takes this write: the front end passes it on for the
  // shared default address, so all parts switch together
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_address_source_reg <= DSD_RST_ADDR_SOURCE; // R11
    end else if (wr_addr_source) begin
      bus_address_source_reg <= i_reg_wr.data; // R12
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [7:0] rd_next;
  always_comb begin
    rd_next = DSD_RD_UNMAPPED;
    for (int k = 0; k < NUM_DIGITS; k++) begin
      if (i_reg_rd_addr == DSD_OFS_DIGIT0 + 8'(k)) begin
        rd_next = digit_reg[k];
      end
    end
    case (i_reg_rd_addr)
      DSD_OFS_DECODE_SELECT: rd_next = digit_decode_select_reg;
      DSD_OFS_FEATURE:       rd_next = feature_reg;
      DSD_OFS_ADDR_SOURCE:   rd_next = bus_address_source_reg;
      default:               rd_next = rd_next;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
    end
  end

  // data holds until the next read, so a slow front end may fetch it late
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rd_data <= DSD_RD_UNMAPPED;
    end else if (i_reg_rd_en) begin
      o_reg_rd_data <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // digit decode
  // ---------------------------------------------------------------
  logic [7:0] scan_byte;
  logic       scan_decoded;
  dsd_font_e  font_sel;
  logic [6:0] font_ag;
  dsd_seg_s   seg_next;

  assign scan_byte    = digit_reg[i_scan_digit];
  assign scan_decoded = digit_decode_select_reg[i_scan_digit]; // R1
  assign font_sel     = feature_reg[DSD_FEAT_HEX_BIT] ? DSD_FONT_HEX : DSD_FONT_BCD; // R2

  dsd_font_rom u_font (
    .i_nibble (scan_byte[3:0]), // R3
    .i_font   (font_sel),       // R6
    .o_seg_ag (font_ag)
  );

  // decimal point bypasses the font so it shows with every character
  always_comb begin
    if (scan_decoded) begin
      seg_next = dsd_seg_s'({scan_byte[7], font_ag}); // R4
    end else begin
      seg_next = dsd_seg_s'(scan_byte); // R5
    end
  end

  // held between strobes so the drivers see a stable pattern per digit slot
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_segments <= dsd_seg_s'(8'h00);
    end else if (i_scan_strobe) begin
      o_segments <= seg_next; // R17
    end
  end

  // ---------------------------------------------------------------
  // self addressing
  // ---------------------------------------------------------------
  // raw strap level, no debounce: a switch here would glitch the address
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      node_sample_reg <= 2'b00;
    end else begin
      node_sample_reg <= {i_node_f_open, i_node_g_open}; // R14 R15
    end
  end

  logic user_addr;
  assign user_addr = bus_address_source_reg[DSD_SRC_USER_BIT]; // R16

  logic [6:0] bus_address_next;
  logic [7:0] key_report_next;

  always_comb begin
    if (user_addr) begin
      bus_address_next = {DSD_DEFAULT_BUS_ADDR[6:2], node_sample_reg}; // R10
      key_report_next  = DSD_KEYS_NO_GF; // R9
    end else begin
      bus_address_next = DSD_DEFAULT_BUS_ADDR; // R16
      key_report_next  = DSD_KEYS_ALL;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_address <= DSD_DEFAULT_BUS_ADDR; // R11
    end else begin
      o_bus_address <= bus_address_next;
    end
  end

  // mask switches in the same cycle as the address, so no key event leaks
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_key_report_mask <= DSD_KEYS_ALL;
    end else begin
      o_key_report_mask <= key_report_next;
    end
  end

endmodule : dsd_decoder

`default_nettype wire

/* core/dsd_pkg.sv */
`default_nettype none

package dsd_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DSD_OFS_DIGIT0        = 8'h01;
  localparam logic [7:0] DSD_OFS_DECODE_SELECT = 8'h09;
  localparam logic [7:0] DSD_OFS_FEATURE       = 8'h0e;
  localparam logic [7:0] DSD_OFS_ADDR_SOURCE   = 8'h2d;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         DSD_FEAT_HEX_BIT      = 2;
  localparam int         DSD_SRC_USER_BIT      = 0;
  localparam int         DSD_NUM_DIGITS        = 8;
  localparam logic [7:0] DSD_RST_DIGIT         = 8'h00;
  localparam logic [7:0] DSD_RST_DECODE        = 8'h00;
  localparam logic [7:0] DSD_RST_FEATURE       = 8'h00;
  localparam logic [7:0] DSD_RST_ADDR_SOURCE   = 8'h00;
  localparam logic [6:0] DSD_DEFAULT_BUS_ADDR  = 7'h00;
  localparam logic [7:0] DSD_KEYS_ALL          = 8'hff;
  localparam logic [7:0] DSD_KEYS_NO_GF        = 8'hfc;
  localparam logic [7:0] DSD_RD_UNMAPPED       = 8'h00;

  // font selection
  typedef enum logic {
    DSD_FONT_BCD,
    DSD_FONT_HEX
  } dsd_font_e;

  // segment drive, laid out as an undecoded digit byte
  typedef struct packed {
    logic decimal_point_segment;
    logic seg_a;
    logic seg_b;
    logic seg_c;
    logic seg_d;
    logic seg_e;
    logic segment_f_line;
    logic segment_g_line;
  } dsd_seg_s;

  // register write request
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } dsd_wr_s;

endpackage : dsd_pkg

`default_nettype wire

/* core/dsd_font_rom.sv */
`timescale 1ns/100ps
`default_nettype none

module dsd_font_rom (
  input  wire logic              [3:0] i_nibble,
  input  wire dsd_pkg::dsd_font_e      i_font,
  output logic                   [6:0] o_seg_ag
);
  import dsd_pkg::*;

  // ---------------------------------------------------------------
  // font tables, bits a..g from msb to lsb
  // ---------------------------------------------------------------
  always_comb begin
    case (i_nibble)
      4'h0:    o_seg_ag = 7'h7e;
      4'h1:    o_seg_ag = 7'h30;
      4'h2:    o_seg_ag = 7'h6d;
      4'h3:    o_seg_ag = 7'h79;
      4'h4:    o_seg_ag = 7'h33;
      4'h5:    o_seg_ag = 7'h5b;
      4'h6:    o_seg_ag = 7'h5f;
      4'h7:    o_seg_ag = 7'h70;
      4'h8:    o_seg_ag = 7'h7f;
      4'h9:    o_seg_ag = 7'h7b;
      // hex A..F in ascending order
      4'ha:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h77 : 7'h01; // R7 R8
      4'hb:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h1f : 7'h4f; // R7 R8
      4'hc:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h4e : 7'h37; // R7 R8
      4'hd:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h3d : 7'h0e; // R7 R8
      4'he:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h4f : 7'h67; // R7 R8
      4'hf:    o_seg_ag = (i_font == DSD_FONT_HEX) ? 7'h47 : 7'h00; // R7 R8
      default: o_seg_ag = 7'h00;
    endcase
  end

endmodule : dsd_font_rom

`default_nettype wire

/* bench/dsd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module dsd_host_model (
  input  wire logic         i_core_clk,
  output dsd_pkg::dsd_wr_s  o_wr,
  output logic              o_rd_en,
  output logic        [7:0] o_rd_addr,
  input  wire logic   [7:0] i_rd_data,
  input  wire logic         i_rd_valid
);
  import dsd_pkg::*;
  initial begin
    o_wr = '0;
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end
  // released lines show the inverse, not a convenient stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1 o_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge i_core_clk);
    #1 o_wr <= '{en: 1'b0, addr: ~a, data: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_core_clk);
    #1 o_rd_en <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_core_clk);
    #1 o_rd_en <= 1'b0;
    o_rd_addr <= ~a;
    d = i_rd_data;
    v = i_rd_valid;
  endtask : rd
  // one broadcast write after power-up sets every device at once
  task automatic self_addr;
    wr(DSD_OFS_ADDR_SOURCE, 8'h01);
  endtask : self_addr
endmodule : dsd_host_model

`default_nettype wire

/* bench/dsd_decoder_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module dsd_decoder_asserts #(
  parameter int NUM_DIGITS = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire dsd_pkg::dsd_wr_s i_reg_wr,
  input  wire logic             i_reg_rd_en,
  input  wire logic       [7:0] i_reg_rd_addr,
  input  wire logic       [7:0] o_reg_rd_data,
  input  wire logic             o_reg_rd_valid,
  input  wire logic             i_scan_strobe,
  input  wire logic       [2:0] i_scan_digit,
  input  wire dsd_pkg::dsd_seg_s o_segments,
  input  wire logic             i_node_g_open,
  input  wire logic             i_node_f_open,
  input  wire logic       [6:0] o_bus_address,
  input  wire logic       [7:0] o_key_report_mask
);
  import dsd_pkg::*;
  logic [7:0] dig_reg [NUM_DIGITS];
  logic [7:0] sel_reg;
  logic [7:0] cur_byte;
  logic       src_wr;
  assign cur_byte = dig_reg[i_scan_digit];
  assign src_wr = i_reg_wr.en && i_reg_wr.addr == DSD_OFS_ADDR_SOURCE;
  // shadow copies so segment checks know the stored bytes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dig_reg <= '{default: 8'h00};
      sel_reg <= 8'h00;
    end else if (i_reg_wr.en) begin
      if (i_reg_wr.addr == DSD_OFS_DECODE_SELECT)
        sel_reg <= i_reg_wr.data;
      else if (i_reg_wr.addr inside {[8'h01:8'h08]})
        dig_reg[3'(i_reg_wr.addr - 8'h01)] <= i_reg_wr.data;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd;
    i_reg_rd_en;
  endsequence
  sequence s_scan;
    i_scan_strobe;
  endsequence
  rd_valid_a: assert property (s_rd |=> o_reg_rd_valid)
    else $error("read valid missing");
  rd_unmap_a: assert property (s_rd ##0 !(i_reg_rd_addr inside {[8'h01:8'h09], 8'h0e, 8'h2d})
    |=> o_reg_rd_data == 8'h00) else $error("unmapped read not zero");
  seg_hold_a: assert property (!i_scan_strobe |=> $stable(o_segments))
    else $error("segments moved without strobe");
  point_direct_a: assert property (s_scan |=> o_segments.decimal_point_segment == $past(cur_byte[7]))
    else $error("decimal point wrong");
  bypass_a: assert property (s_scan ##0 !sel_reg[i_scan_digit] |=> o_segments == $past(cur_byte))
    else $error("undecoded digit wrong");
  src_factory_a: assert property (src_wr && !i_reg_wr.data[0] |=> ##1
    (o_bus_address == DSD_DEFAULT_BUS_ADDR && o_key_report_mask == DSD_KEYS_ALL)) else $error("factory address wrong");
  src_user_a: assert property (src_wr && i_reg_wr.data[0] |=> ##1 o_key_report_mask == DSD_KEYS_NO_GF)
    else $error("key nodes still reporting");
  addr_nodes_a: assert property (o_key_report_mask == DSD_KEYS_NO_GF |->
    o_bus_address == {5'h00, $past(i_node_f_open, 2), $past(i_node_g_open, 2)}) else $error("user address wrong");
endmodule : dsd_decoder_asserts

bind dsd_decoder dsd_decoder_asserts #(.NUM_DIGITS(NUM_DIGITS)) u_chk (.*);

`default_nettype wire

/* bench/digit_segment_decoder_test.sv */
`timescale 1ns/100ps
`default_nettype none

module digit_segment_decoder_test;
  import dsd_pkg::*;
  localparam logic [6:0] BCD [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                                      7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e, 7'h67, 7'h00};
  localparam logic [6:0] HEX [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                                      7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
  logic       i_core_clk, i_rst_n, strobe, node_g, node_f, rd_en, rd_valid, v;
  logic [2:0] digit;
  logic [7:0] rd_addr, rd_data, key_mask, d;
  logic [6:0] bus_addr;
  dsd_wr_s    wr;
  dsd_seg_s   segs;
  int         err_total, cmp_count;
  dsd_decoder #(.NUM_DIGITS(8)) uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr),
    .i_reg_rd_en(rd_en), .i_reg_rd_addr(rd_addr), .o_reg_rd_data(rd_data), .o_reg_rd_valid(rd_valid),
    .i_scan_strobe(strobe), .i_scan_digit(digit), .o_segments(segs), .i_node_g_open(node_g),
    .i_node_f_open(node_f), .o_bus_address(bus_addr), .o_key_report_mask(key_mask));
  dsd_host_model host (.i_core_clk(i_core_clk), .o_wr(wr), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .i_rd_valid(rd_valid));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic scan(input logic [2:0] dg);
    @(posedge i_core_clk);
    #1 strobe <= 1'b1;
    digit <= dg;
    @(posedge i_core_clk);
    #1 strobe <= 1'b0;
  endtask : scan
  task automatic t_regs;
    chk(segs, 8'h00);
    chk({1'b0, bus_addr}, 8'h00);
    host.wr(DSD_OFS_DECODE_SELECT, 8'h25);
    host.rd(DSD_OFS_DECODE_SELECT, d, v);
    chk(d, 8'h25);
    chk({7'h00, v}, 8'h01);
    host.rd(8'h40, d, v);
    chk(d, DSD_RD_UNMAPPED);
    host.wr(DSD_OFS_ADDR_SOURCE, 8'hfe);
    host.rd(DSD_OFS_ADDR_SOURCE, d, v);
    chk(d, 8'hfe);
    chk({1'b0, bus_addr}, 8'h00);
  endtask : t_regs
  // odd bits six to four and a toggling point stress the nibble-only lookup
  task automatic t_fonts;
    for (int f = 0; f < 2; f++) begin
      host.wr(DSD_OFS_FEATURE, 8'(f) << DSD_FEAT_HEX_BIT);
      for (int n = 0; n < 16; n++) begin
        host.wr(DSD_OFS_DIGIT0, {n[0], 3'(n) ^ 3'h5, 4'(n)});
        scan(3'h0);
        chk(segs, {n[0], f[0] ? HEX[n] : BCD[n]});
      end
    end
  endtask : t_fonts
  task automatic t_bypass;
    host.wr(DSD_OFS_DIGIT0 + 8'h01, 8'ha5);
    scan(3'h1);
    chk(segs, 8'ha5);
    host.wr(DSD_OFS_DIGIT0 + 8'h02, 8'hf3);
    scan(3'h2);
    chk(segs, {1'b1, 7'h79});
  endtask : t_bypass
  task automatic t_addr;
    host.self_addr();
    @(posedge i_core_clk);
    #1 chk({1'b0, bus_addr}, {6'h00, node_f, node_g});
    chk(key_mask, DSD_KEYS_NO_GF);
    node_g <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 chk({1'b0, bus_addr}, 8'h03);
    host.wr(DSD_OFS_ADDR_SOURCE, 8'h00);
    @(posedge i_core_clk);
    #1 chk({1'b0, bus_addr}, 8'h00);
    chk(key_mask, DSD_KEYS_ALL);
  endtask : t_addr
  initial begin
    i_rst_n = 1'b0;
    strobe = 1'b0;
    digit = 3'h0;
    node_g = 1'b0;
    node_f = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    t_regs();
    t_fonts();
    t_bypass();
    t_addr();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge i_core_clk);
    err_total++;
    end_sim();
  end
endmodule : digit_segment_decoder_test

`default_nettype wire
